//--- common/pmr_defines.vh
// constants of the mask and system control register bank
// assumes a 10 MHz core clock and a 9-bit paged register address
`ifndef PMR_DEFINES_VH
`define PMR_DEFINES_VH
// full 9-bit register addresses
`define PMR_ADDR_EVENT_A 9'h006
`define PMR_ADDR_EVENT_B 9'h007
`define PMR_ADDR_EVENT_C 9'h008
`define PMR_ADDR_MASK_A 9'h00A
`define PMR_ADDR_MASK_B 9'h00B
`define PMR_ADDR_MASK_C 9'h00C
`define PMR_ADDR_CTRL_A 9'h00E
`define PMR_ADDR_CTRL_B 9'h00F
`define PMR_ADDR_CTRL_C 9'h010
`define PMR_ADDR_CTRL_D 9'h011
`define PMR_ADDR_CTRL_E 9'h012
`define PMR_LOCK_LO 9'h081
`define PMR_LOCK_HI 9'h120
`define PMR_LOCK_EXEMPT 9'h100
// implemented bits of each register
`define PMR_BITS_EV_A 8'h19
`define PMR_BITS_EV_B 8'hAA
`define PMR_BITS_EV_C 8'h1F
`define PMR_BITS_CTRL_A 8'h78
`define PMR_BITS_CTRL_B 8'hFE
`define PMR_BITS_CTRL_C 8'hFF
`define PMR_BITS_CTRL_D 8'h07
`define PMR_BITS_CTRL_E 8'h80
`define PMR_BITS_PAGE 8'hC3
// field positions
`define PMR_CA_SYS_TGT 0
`define PMR_CA_SYS_WMASK 4
`define PMR_CB_FREEZE_EN 2
`define PMR_CB_RES_MODE 3
`define PMR_CB_WDOG_PD 1
`define PMR_CC_OTP_DEFAULT_SUPPLIES 7
`define PMR_CC_OTP_RELOAD 4
`define PMR_CE_LOCK 7
`define PMR_PG_REVERT 7
// reset values
`define PMR_RST_REG 8'h00
`define PMR_RST_ADDR 7'h2A
// timing
`define PMR_CLK_PERIOD_NS 100
`define PMR_RAMP_NS_0 4000
`define PMR_RAMP_NS_1 2000
`define PMR_RAMP_NS_2 1000
`define PMR_RAMP_NS_3 500
`define PMR_DEB_US_1 100
`define PMR_DEB_US_2 1000
`define PMR_DEB_US_3 10240
`define PMR_DEB_US_4 51200
`define PMR_DEB_US_5 256000
`define PMR_DEB_US_6 512000
`define PMR_DEB_US_7 1024000
`define PMR_WDOG_BASE_MS 2048
`endif

//--- verilog/pmr_ctrl_regs.v
// mask and system control register bank behind a two-wire bus slave
// assumes scl/sda already synchronous to ref_clk_in; sequencer is outside
//
// Function
// - system mask register: sequencer-done bit 4, watchdog warning 3, power key 0.
// - supply mask register: under-voltage 7, ramp done 5, over-current 3, temperature 1.
// - input mask register bits 4..0 mask the matching general input event.
// - control A bits 0,1,2 hold system, main, secondary domain targets.
// - a domain target bit changes only when its write-mask bit 4/5/6 is set.
// - bit 3 picks full power-down to slot 0 or partial-down pointer.
// - control B bit 7 enables buck soft start.
// - freeze enable blocks wakeups once restart trials reach the limit field.
// - key lock bit 4 puts power-down under the key-press delay.
// - reset policy bit 3 asserts reset output during power-down when set.
// - control B bit 1 keeps the watchdog running during power-down.
// - control C bit 7 loads OTP supply defaults on entering slot 0.
// - field 6:5 gives ramp time per step, doubled for second buck.
// - control C bit 4 reloads supplies from OTP on leaving power-down.
// - auto-boot bit 3 starts the sequencer without a wakeup event.
// - field 2:0 selects the common input debounce time.
// - scale zero disables watchdog, else timeout 2.048 s times 2^(N-1).
// - lock bit blocks writes to 0x81..0x120 except 0x100.
// - latched event flags clear when the host writes ones to them.
// - page field supplies upper address bits; 01 selects 0x80..0xFF.
`timescale 1ns/1ps
`default_nettype none
`include "pmr_defines.vh"
module pmr_ctrl_regs #(
  parameter [6:0] DEV_ADDR = `PMR_RST_ADDR, // arbitrary bus address
  parameter integer DEB_CYC_2 = `PMR_DEB_US_2 * 1000 / `PMR_CLK_PERIOD_NS,
  parameter integer DEB_CYC_3 = `PMR_DEB_US_3 * 1000 / `PMR_CLK_PERIOD_NS,
  parameter integer DEB_CYC_4 = `PMR_DEB_US_4 * 1000 / `PMR_CLK_PERIOD_NS,
  parameter integer DEB_CYC_5 = `PMR_DEB_US_5 * 10 * (100 / `PMR_CLK_PERIOD_NS),
  parameter integer DEB_CYC_6 = `PMR_DEB_US_6 * 10 * (100 / `PMR_CLK_PERIOD_NS),
  parameter integer DEB_CYC_7 = `PMR_DEB_US_7 * 10 * (100 / `PMR_CLK_PERIOD_NS),
  parameter integer WDOG_BASE_CYC = `PMR_WDOG_BASE_MS * (1000000 / `PMR_CLK_PERIOD_NS)
) (
  // clock and reset
  input wire ref_clk_in,
  input wire rst_in,
  // two-wire bus
  input wire scl_in,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe_n_out,
  // event pulses and sequencer state
  input wire [7:0] ev_sys_set_in,
  input wire [7:0] ev_supply_set_in,
  input wire [7:0] ev_input_set_in,
  input wire powerdown_active_in,
  input wire slot0_entry_in,
  input wire powerdown_exit_in,
  input wire [1:0] restart_trials_in,
  // interrupt and power domain control
  output wire irq_request_out,
  output wire system_domain_target_out,
  output wire main_domain_target_out,
  output wire secondary_domain_target_out,
  output wire partial_powerdown_out,
  output wire soft_start_enable_out,
  output wire key_powerdown_lock_out,
  output wire auto_boot_out,
  output wire system_reset_output_n_out,
  output wire otp_default_supplies_load_out,
  output wire otp_reload_on_wake_out,
  // watchdog and timing selections
  output wire wakeup_block_out,
  output wire wdog_run_out,
  output wire wdog_enable_out,
  output wire [31:0] wdog_timeout_cycles_out,
  output wire [7:0] ramp_step_cycles_out,
  output wire [7:0] ramp_step_cycles_wide_out,
  output wire [23:0] debounce_cycles_out,
  output wire register_write_lock_out
);
  localparam [2:0] S_IDLE = 3'h0, S_ADDR = 3'h1, S_AACK = 3'h2, S_REG = 3'h3,
    S_WACK = 3'h4, S_WDATA = 3'h5, S_RDATA = 3'h6, S_RMACK = 3'h7;
  localparam integer RAMP_I0 = `PMR_RAMP_NS_0 / `PMR_CLK_PERIOD_NS,
    RAMP_I1 = `PMR_RAMP_NS_1 / `PMR_CLK_PERIOD_NS, RAMP_I2 = `PMR_RAMP_NS_2 / `PMR_CLK_PERIOD_NS,
    RAMP_I3 = `PMR_RAMP_NS_3 / `PMR_CLK_PERIOD_NS;
  localparam integer DEB_CYC_1 = `PMR_DEB_US_1 * 1000 / `PMR_CLK_PERIOD_NS;
  reg [2:0] state_q;
  reg [3:0] cnt_q;
  reg [7:0] shreg_q, txbyte_q, ptr_q, wdata_q, page_q, ramp_q;
  reg rw_q, scl_q, sda_q, sda_oe_n_q, wr_q, acc_q, irq_q, wake_blk_q, rst_n_q;
  reg wdog_run_q, wdog_en_q, otp_load_q, otp_reload_q;
  reg [8:0] waddr_q;
  reg [7:0] mask_a_q, mask_b_q, mask_c_q, ev_a_q, ev_b_q, ev_c_q;
  reg [7:0] ctl_a_q, ctl_b_q, ctl_c_q, ctl_d_q, ctl_e_q;
  reg [23:0] deb_q;
  reg [31:0] wdog_to_q;
  wire [8:0] cur_addr = {page_q[1:0], ptr_q[6:0]};
  wire start_det = scl_q && scl_in && sda_q && !sda_in;
  wire stop_det = scl_q && scl_in && !sda_q && sda_in;
  wire scl_rise = !scl_q && scl_in;
  wire scl_fall = scl_q && !scl_in;
  wire byte_done = scl_fall && (cnt_q == 4'h8);
  // write lock covers 0x081..0x120, apart from the 0x100 mirror
  wire lock_hit = ctl_e_q[`PMR_CE_LOCK] && (waddr_q >= `PMR_LOCK_LO) &&
                  (waddr_q <= `PMR_LOCK_HI) && (waddr_q != `PMR_LOCK_EXEMPT);
  wire wr_ok = wr_q && !lock_hit;
  wire pg_wr = wr_ok && (waddr_q[6:0] == 7'h00);
  wire [7:0] rd_data = reg_read(cur_addr);
  // read decode; unmapped and reserved bits read zero
  function [7:0] reg_read;
    input [8:0] a;
    begin
      case (a)
        9'h000, 9'h080, 9'h100, 9'h180: reg_read = page_q; // page control mirrors
        `PMR_ADDR_EVENT_A: reg_read = ev_a_q | {1'b0, |ev_c_q, |ev_b_q, 5'h00};
        `PMR_ADDR_EVENT_B: reg_read = ev_b_q;
        `PMR_ADDR_EVENT_C: reg_read = ev_c_q;
        `PMR_ADDR_MASK_A: reg_read = mask_a_q;
        `PMR_ADDR_MASK_B: reg_read = mask_b_q;
        `PMR_ADDR_MASK_C: reg_read = mask_c_q;
        `PMR_ADDR_CTRL_A: reg_read = ctl_a_q;
        `PMR_ADDR_CTRL_B: reg_read = ctl_b_q;
        `PMR_ADDR_CTRL_C: reg_read = ctl_c_q;
        `PMR_ADDR_CTRL_D: reg_read = ctl_d_q;
        `PMR_ADDR_CTRL_E: reg_read = ctl_e_q;
        default: reg_read = 8'h00;
      endcase
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // two-wire slave; pointer auto-increments, consecutive write style only
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= S_IDLE; // datapath registers are loaded before use
      ptr_q <= 8'h00;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sda_oe_n_q <= 1'b1;
      wr_q <= 1'b0;
      acc_q <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      wr_q <= 1'b0;
      acc_q <= 1'b0;
      if (start_det) begin
        state_q <= S_ADDR; // repeated start restarts the frame
        cnt_q <= 4'h0;
        sda_oe_n_q <= 1'b1;
      end else if (stop_det) begin
        state_q <= S_IDLE;
        sda_oe_n_q <= 1'b1;
      end else begin
        if (scl_rise && (state_q == S_ADDR || state_q == S_REG || state_q == S_WDATA)) begin
          shreg_q <= {shreg_q[6:0], sda_in};
          cnt_q <= cnt_q + 4'h1;
        end
        case (state_q)
          S_ADDR: if (byte_done) begin
            cnt_q <= 4'h0;
            if (shreg_q[7:1] == DEV_ADDR) begin
              rw_q <= shreg_q[0];
              sda_oe_n_q <= 1'b0; // acknowledge
              state_q <= S_AACK;
            end else begin
              state_q <= S_IDLE;
            end
          end
          S_AACK: if (scl_fall) begin
            if (rw_q) begin
              txbyte_q <= rd_data;
              sda_oe_n_q <= rd_data[7];
              cnt_q <= 4'h1;
              state_q <= S_RDATA;
            end else begin
              sda_oe_n_q <= 1'b1;
              state_q <= S_REG;
            end
          end
          S_REG: if (byte_done) begin
            ptr_q <= shreg_q;
            cnt_q <= 4'h0;
            sda_oe_n_q <= 1'b0;
            state_q <= S_WACK;
          end
          S_WACK: if (scl_fall) begin
            sda_oe_n_q <= 1'b1;
            state_q <= S_WDATA;
          end
          S_WDATA: if (byte_done) begin
            wr_q <= 1'b1;
            waddr_q <= cur_addr;
            wdata_q <= shreg_q;
            ptr_q <= ptr_q + 8'h01;
            cnt_q <= 4'h0;
            sda_oe_n_q <= 1'b0; // acked even when locked
            state_q <= S_WACK;
          end
          S_RDATA: if (scl_fall) begin
            if (cnt_q == 4'h8) begin
              sda_oe_n_q <= 1'b1;
              ptr_q <= ptr_q + 8'h01;
              acc_q <= 1'b1;
              state_q <= S_RMACK;
            end else begin
              sda_oe_n_q <= txbyte_q[6];
              txbyte_q <= {txbyte_q[6:0], 1'b0};
              cnt_q <= cnt_q + 4'h1;
            end
          end
          S_RMACK: if (scl_rise && sda_in) begin
            state_q <= S_IDLE; // master nack ends the read
          end else if (scl_fall) begin
            txbyte_q <= rd_data;
            sda_oe_n_q <= rd_data[7];
            cnt_q <= 4'h1;
            state_q <= S_RDATA;
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // register writes; masking with the valid bits drops reserved bits
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      page_q <= `PMR_RST_REG;
      mask_a_q <= `PMR_RST_REG;
      mask_b_q <= `PMR_RST_REG;
      mask_c_q <= `PMR_RST_REG;
      ctl_a_q <= `PMR_RST_REG;
      ctl_b_q <= `PMR_RST_REG;
      ctl_c_q <= `PMR_RST_REG;
      ctl_d_q <= `PMR_RST_REG;
      ctl_e_q <= `PMR_RST_REG;
    end else begin
      if (pg_wr) begin
        page_q <= wdata_q & `PMR_BITS_PAGE;
      end else if ((acc_q || wr_q) && page_q[`PMR_PG_REVERT]) begin
        page_q <= {page_q[7:2], 2'b00}; // one-shot page access
      end
      if (wr_ok) begin
        case (waddr_q)
          `PMR_ADDR_MASK_A: mask_a_q <= wdata_q & `PMR_BITS_EV_A;
          `PMR_ADDR_MASK_B: mask_b_q <= wdata_q & `PMR_BITS_EV_B;
          `PMR_ADDR_MASK_C: mask_c_q <= wdata_q & `PMR_BITS_EV_C;
          `PMR_ADDR_CTRL_A: begin
            ctl_a_q[6:3] <= wdata_q[6:3];
            // each target bit moves only with its mask bit in the same write
            if (wdata_q[`PMR_CA_SYS_WMASK]) ctl_a_q[0] <= wdata_q[0];
            if (wdata_q[`PMR_CA_SYS_WMASK + 1]) ctl_a_q[1] <= wdata_q[1];
            if (wdata_q[`PMR_CA_SYS_WMASK + 2]) ctl_a_q[2] <= wdata_q[2];
          end
          `PMR_ADDR_CTRL_B: ctl_b_q <= wdata_q & `PMR_BITS_CTRL_B;
          `PMR_ADDR_CTRL_C: ctl_c_q <= wdata_q & `PMR_BITS_CTRL_C;
          `PMR_ADDR_CTRL_D: ctl_d_q <= wdata_q & `PMR_BITS_CTRL_D;
          `PMR_ADDR_CTRL_E: ctl_e_q <= wdata_q & `PMR_BITS_CTRL_E;
          default: ;
        endcase
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // event flags: a set in the cycle of a clear wins, so nothing is lost
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      ev_a_q <= 8'h00;
      ev_b_q <= 8'h00;
      ev_c_q <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      ev_a_q <= (ev_a_q & ~((wr_ok && waddr_q == `PMR_ADDR_EVENT_A) ? wdata_q : 8'h00)) |
                (ev_sys_set_in & `PMR_BITS_EV_A);
      ev_b_q <= (ev_b_q & ~((wr_ok && waddr_q == `PMR_ADDR_EVENT_B) ? wdata_q : 8'h00)) |
                (ev_supply_set_in & `PMR_BITS_EV_B);
      ev_c_q <= (ev_c_q & ~((wr_ok && waddr_q == `PMR_ADDR_EVENT_C) ? wdata_q : 8'h00)) |
                (ev_input_set_in & `PMR_BITS_EV_C);
      irq_q <= |(ev_a_q & ~mask_a_q) | |(ev_b_q & ~mask_b_q) | |(ev_c_q & ~mask_c_q);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // derived controls, registered so every output leaves a flip-flop
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      wake_blk_q <= 1'b0;
      rst_n_q <= 1'b1;
      wdog_run_q <= 1'b0;
      wdog_en_q <= 1'b0;
      otp_load_q <= 1'b0;
      otp_reload_q <= 1'b0;
      ramp_q <= RAMP_I0[7:0];
      deb_q <= 24'h000000;
      wdog_to_q <= 32'h00000000;
    end else begin
      wake_blk_q <= ctl_b_q[`PMR_CB_FREEZE_EN] && (restart_trials_in >= ctl_b_q[6:5]);
      wdog_en_q <= (ctl_d_q[2:0] != 3'h0);
      rst_n_q <= !(ctl_b_q[`PMR_CB_RES_MODE] && powerdown_active_in);
      wdog_run_q <= (ctl_d_q[2:0] != 3'h0) &&
                    (!powerdown_active_in || ctl_b_q[`PMR_CB_WDOG_PD]);
      otp_load_q <= slot0_entry_in && ctl_c_q[`PMR_CC_OTP_DEFAULT_SUPPLIES];
      otp_reload_q <= powerdown_exit_in && ctl_c_q[`PMR_CC_OTP_RELOAD];
      case (ctl_c_q[6:5])
        2'h0: ramp_q <= RAMP_I0[7:0];
        2'h1: ramp_q <= RAMP_I1[7:0];
        2'h2: ramp_q <= RAMP_I2[7:0];
        default: ramp_q <= RAMP_I3[7:0];
      endcase
      case (ctl_c_q[2:0])
        3'h0: deb_q <= 24'h000000;
        3'h1: deb_q <= DEB_CYC_1[23:0];
        3'h2: deb_q <= DEB_CYC_2[23:0];
        3'h3: deb_q <= DEB_CYC_3[23:0];
        3'h4: deb_q <= DEB_CYC_4[23:0];
        3'h5: deb_q <= DEB_CYC_5[23:0];
        3'h6: deb_q <= DEB_CYC_6[23:0];
        default: deb_q <= DEB_CYC_7[23:0];
      endcase
      wdog_to_q <= (ctl_d_q[2:0] == 3'h0) ? 32'h00000000 :
                   (WDOG_BASE_CYC[31:0] << (ctl_d_q[2:0] - 3'h1));
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops, apart from the constant-low sda_out
  assign sda_out = 1'b0; // open drain: only ever pulls low
  assign sda_oe_n_out = sda_oe_n_q;
  assign irq_request_out = irq_q;
  assign system_domain_target_out = ctl_a_q[0];
  assign main_domain_target_out = ctl_a_q[1];
  assign secondary_domain_target_out = ctl_a_q[2];
  assign partial_powerdown_out = ctl_a_q[3];
  assign soft_start_enable_out = ctl_b_q[7];
  assign key_powerdown_lock_out = ctl_b_q[4];
  assign auto_boot_out = ctl_c_q[3];
  assign system_reset_output_n_out = rst_n_q;
  assign otp_default_supplies_load_out = otp_load_q;
  assign otp_reload_on_wake_out = otp_reload_q;
  assign wakeup_block_out = wake_blk_q;
  assign wdog_run_out = wdog_run_q;
  assign wdog_enable_out = wdog_en_q;
  assign wdog_timeout_cycles_out = wdog_to_q;
  assign ramp_step_cycles_out = ramp_q;
  assign ramp_step_cycles_wide_out = {ramp_q[6:0], 1'b0};
  assign debounce_cycles_out = deb_q;
  assign register_write_lock_out = ctl_e_q[`PMR_CE_LOCK];
endmodule
`default_nettype wire

//--- testbench/pmr_ctrl_regs_chk.sv
// checker for the mask and system control register bank
// sees only top module ports; bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module pmr_ctrl_regs_chk #(
  parameter integer WDOG_BASE_CYC = 64
) (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // sequencer state
  input wire logic powerdown_active_in,
  input wire logic slot0_entry_in,
  input wire logic powerdown_exit_in,
  // watched outputs
  input wire logic irq_request_out,
  input wire logic system_reset_output_n_out,
  input wire logic otp_default_supplies_load_out,
  input wire logic otp_reload_on_wake_out,
  input wire logic wakeup_block_out,
  input wire logic wdog_run_out,
  input wire logic wdog_enable_out,
  input wire logic [31:0] wdog_timeout_cycles_out,
  input wire logic [7:0] ramp_step_cycles_out,
  input wire logic [7:0] ramp_step_cycles_wide_out
);
////////////////////////////////////////////////////////////////////////////////
  // one clock domain, so clocking and disable are shared
  default clocking dc @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);
  // timeout is the base times 1, 2, 4 .. 64
  logic [31:0] tmo_mult;
  logic scale_ok;
  assign tmo_mult = wdog_timeout_cycles_out / WDOG_BASE_CYC;
  assign scale_ok = (wdog_timeout_cycles_out % WDOG_BASE_CYC == 0) && $onehot(tmo_mult)
                    && tmo_mult <= 32'h40;
////////////////////////////////////////////////////////////////////////////////
  // derived outputs lag their cause by one clock
  rst_out_a: assert property (!$past(powerdown_active_in) |-> system_reset_output_n_out)
    else $error("reset output low outside power-down");
  otp_default_supplies_a: assert property (otp_default_supplies_load_out |-> $past(slot0_entry_in))
    else $error("otp supply load without slot 0 entry");
  otp_reload_a: assert property (otp_reload_on_wake_out |-> $past(powerdown_exit_in))
    else $error("otp reload without power-down exit");
  wd_off_a: assert property (!wdog_enable_out |-> wdog_timeout_cycles_out == 32'h0)
    else $error("timeout nonzero with watchdog off");
  wd_scale_a: assert property (wdog_enable_out |-> scale_ok)
    else $error("timeout not a scaled base value");
  wd_run_a: assert property (wdog_run_out |-> wdog_enable_out)
    else $error("watchdog runs while disabled");
  wd_awake_a: assert property (wdog_enable_out && !$past(powerdown_active_in) |-> wdog_run_out)
    else $error("watchdog stopped while awake");
  ramp_pair_a: assert property (ramp_step_cycles_wide_out == {ramp_step_cycles_out[6:0], 1'h0})
    else $error("wide ramp step not double");
  ramp_set_a: assert property (ramp_step_cycles_out inside {8'h28, 8'h14, 8'h0A, 8'h05})
    else $error("ramp step outside the four codes");
  // main scenarios reached
  cover property (otp_default_supplies_load_out);
  cover property ($rose(irq_request_out));
  cover property (wakeup_block_out && wdog_run_out);
endmodule
`default_nettype wire

//--- testbench/pmr_host.sv
// host processor model: two-wire bus master with write and read tasks
// assumes an open-drain sda resolved outside; each scl phase >= 4 clocks
`timescale 1ns/1ps
`default_nettype none
module pmr_host #(
  parameter logic [6:0] DEV = 7'h2A
) (
  // clock and resolved data line
  input wire logic ref_clk_in,
  input wire logic sda_in,
  // master side of the bus, 1 means released
  output logic scl_out,
  output logic sda_out
);
  // bus idle from time zero
  initial begin
    scl_out = 1'h1;
    sda_out = 1'h1;
  end
////////////////////////////////////////////////////////////////////////////////
  // every change lands just after a clock edge
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  // start or repeated start; sda is released while scl is low, then falls while scl is high
  task automatic start();
    sda_out = 1'h1;
    tick(4);
    scl_out = 1'h1;
    tick(5);
    sda_out = 1'h0;
    tick(5);
    scl_out = 1'h0;
    tick(2);
  endtask
  task automatic stop();
    sda_out = 1'h0;
    tick(4);
    scl_out = 1'h1;
    tick(5);
    sda_out = 1'h1;
    tick(5);
  endtask
  // one bit; the two clocks after the fall give the slave its hold time
  task automatic bitio(input logic b, output logic r);
    sda_out = b;
    tick(4);
    scl_out = 1'h1;
    tick(3);
    r = sda_in;
    tick(2);
    scl_out = 1'h0;
    tick(2);
  endtask
  // eight bits then the ninth released: ack is seen as 0
  task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic nak);
    for (int i = 7; i >= 0; i--)
      bitio(d[i], q[i]);
    bitio(1'h1, nak);
  endtask
  task automatic wr(input logic [6:0] p, input logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    xfer({DEV, 1'h0}, q, n0);
    xfer({1'h0, p}, q, n1);
    xfer(d, q, n2);
    stop();
    nak = n0 | n1 | n2;
  endtask
  // single byte read ends with a master nack
  task automatic rd(input logic [6:0] p, output logic [7:0] d, output logic nak);
    logic [7:0] q;
    logic n0, n1, n2, n3;
    start();
    xfer({DEV, 1'h0}, q, n0);
    xfer({1'h0, p}, q, n1);
    start();
    xfer({DEV, 1'h1}, q, n2);
    xfer(8'hFF, d, n3);
    stop();
    nak = n0 | n1 | n2;
  endtask
endmodule
`default_nettype wire

//--- testbench/pmr_ctrl_regs_tb_top.sv
// self-checking bench for the mask and system control register bank
// assumes host model and checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module pmr_ctrl_regs_tb_top;
  localparam int WB = 64;
  int fails = 0;
  int compares = 0;
  logic ref_clk_in, rst_in, powerdown_active_in, slot0_entry_in, powerdown_exit_in;
  logic [7:0] ev_sys_set_in, ev_supply_set_in, ev_input_set_in;
  logic [1:0] restart_trials_in;
  wire scl_in, sda_in, host_sda, sda_out, sda_oe_n_out, irq_request_out;
  wire system_domain_target_out, main_domain_target_out, secondary_domain_target_out;
  wire partial_powerdown_out, soft_start_enable_out, key_powerdown_lock_out;
  wire auto_boot_out, system_reset_output_n_out, otp_default_supplies_load_out;
  wire otp_reload_on_wake_out, wakeup_block_out, wdog_run_out, wdog_enable_out;
  wire register_write_lock_out;
  wire [31:0] wdog_timeout_cycles_out;
  wire [7:0] ramp_step_cycles_out, ramp_step_cycles_wide_out;
  wire [23:0] debounce_cycles_out;
  wire [2:0] tgt;
  // open-drain wire with pull-up: low if either side pulls
  assign sda_in = host_sda & (sda_oe_n_out | sda_out);
  assign tgt = {secondary_domain_target_out, main_domain_target_out, system_domain_target_out};
////////////////////////////////////////////////////////////////////////////////
  // short debounce and watchdog counts keep the run brief
  pmr_ctrl_regs #(.DEB_CYC_3(24'h1E), .DEB_CYC_4(24'h28),
    .DEB_CYC_5(24'h32), .DEB_CYC_6(24'h3C), .DEB_CYC_7(24'h46), .WDOG_BASE_CYC(WB))
  pmr_ctrl_regs_i (.ref_clk_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_n_out,
    .ev_sys_set_in, .ev_supply_set_in, .ev_input_set_in, .powerdown_active_in,
    .slot0_entry_in, .powerdown_exit_in, .restart_trials_in, .irq_request_out,
    .system_domain_target_out, .main_domain_target_out, .secondary_domain_target_out,
    .partial_powerdown_out, .soft_start_enable_out, .key_powerdown_lock_out, .auto_boot_out,
    .system_reset_output_n_out, .otp_default_supplies_load_out, .otp_reload_on_wake_out,
    .wakeup_block_out, .wdog_run_out, .wdog_enable_out, .wdog_timeout_cycles_out,
    .ramp_step_cycles_out, .ramp_step_cycles_wide_out, .debounce_cycles_out,
    .register_write_lock_out);
  pmr_host pmr_host_i (.ref_clk_in, .sda_in, .scl_out(scl_in), .sda_out(host_sda));
////////////////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #1;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [6:0] p, input logic [7:0] d);
    logic n;
    pmr_host_i.wr(p, d, n);
    chk(n, 32'h0);
  endtask
  // read one register; a missing ack shows in the top bit
  task automatic r(input logic [6:0] p, input logic [7:0] e);
    logic [7:0] q;
    logic n;
    pmr_host_i.rd(p, q, n);
    chk({n, q}, {1'h0, e});
  endtask
  task automatic results();
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////////
  // reset value, all-ones pattern, then clear, on each plain register
  task automatic t_regs();
    logic [6:0] a [7] = '{7'h0A, 7'h0B, 7'h0C, 7'h0F, 7'h10, 7'h11, 7'h12};
    logic [7:0] m [7] = '{8'h19, 8'hAA, 8'h1F, 8'hFE, 8'hFF, 8'h07, 8'h80};
    for (int i = 0; i < 7; i++) begin
      r(a[i], 8'h00);
      w(a[i], 8'hFF);
      r(a[i], m[i]);
      w(a[i], 8'h00);
      r(a[i], 8'h00);
    end
  endtask
  // target bits move only with their own mask bit in the same byte
  task automatic t_domain();
    w(7'h0E, 8'h07);
    chk(tgt, 32'h0);
    w(7'h0E, 8'h1F);
    chk(tgt, 32'h1);
    w(7'h0E, 8'h67);
    chk(tgt, 32'h7);
    w(7'h0E, 8'h28);
    chk({partial_powerdown_out, tgt}, 32'hD);
  endtask
  task automatic t_policy();
    w(7'h0F, 8'hDE);
    chk({soft_start_enable_out, key_powerdown_lock_out}, 32'h3);
    restart_trials_in = 2'h1;
    tick(2);
    chk(wakeup_block_out, 32'h0);
    restart_trials_in = 2'h2;
    tick(2);
    chk(wakeup_block_out, 32'h1);
    powerdown_active_in = 1'h1;
    w(7'h11, 8'h03);
    chk({system_reset_output_n_out, wdog_run_out}, 32'h1);
    chk(wdog_timeout_cycles_out, WB << 2);
    w(7'h0F, 8'hD4);
    chk({system_reset_output_n_out, wdog_run_out}, 32'h2);
    powerdown_active_in = 1'h0;
    tick(2);
    chk(wdog_run_out, 32'h1);
    w(7'h11, 8'h00);
    chk(wdog_timeout_cycles_out | wdog_enable_out, 32'h0);
  endtask
  // c * 33 puts the code in both the slew field and the debounce field
  task automatic t_ctrl_c();
    logic [23:0] deb [8] = '{24'h0, 24'h3E8, 24'h2710, 24'h1E, 24'h28, 24'h32, 24'h3C, 24'h46};
    logic [1:0] p0, p1;
    for (int c = 0; c < 8; c++) begin
      w(7'h10, 8'h98 | 8'(c * 33));
      chk(ramp_step_cycles_out, 32'h28 >> (c % 4));
      chk(ramp_step_cycles_wide_out, 32'h50 >> (c % 4));
      chk(debounce_cycles_out, deb[c]);
    end
    chk(auto_boot_out, 32'h1);
    slot0_entry_in = 1'h1;
    powerdown_exit_in = 1'h1;
    tick(1);
    slot0_entry_in = 1'h0;
    powerdown_exit_in = 1'h0;
    p0 = {otp_default_supplies_load_out, otp_reload_on_wake_out};
    tick(1);
    p1 = {otp_default_supplies_load_out, otp_reload_on_wake_out};
    chk(p0 ^ p1, 32'h3);
    chk(p0 & p1, 32'h0);
  endtask
  // flags latch, masks hide them, writing ones to the flag bits clears them
  task automatic t_irq();
    w(7'h0C, 8'h01);
    w(7'h0B, 8'h80);
    ev_sys_set_in = 8'h10;
    ev_supply_set_in = 8'h80;
    ev_input_set_in = 8'h01;
    tick(1);
    ev_sys_set_in = 8'h00;
    ev_supply_set_in = 8'h00;
    ev_input_set_in = 8'h00;
    tick(2);
    chk(irq_request_out, 32'h1);
    r(7'h06, 8'h70);
    w(7'h06, 8'h10);
    chk(irq_request_out, 32'h0);
    w(7'h0C, 8'h00);
    chk(irq_request_out, 32'h1);
    w(7'h08, 8'h01);
    w(7'h07, 8'h80);
    w(7'h0B, 8'h00);
    chk(irq_request_out, 32'h0);
  endtask
  // lock leaves low page registers and the page register at 0x100 writable
  task automatic t_lock();
    w(7'h12, 8'h80);
    chk(register_write_lock_out, 32'h1);
    w(7'h0A, 8'h19);
    r(7'h0A, 8'h19);
    w(7'h00, 8'h01);
    r(7'h0A, 8'h00);
    w(7'h00, 8'h02);
    w(7'h00, 8'h03);
    r(7'h00, 8'h03);
    w(7'h00, 8'h00);
    r(7'h12, 8'h80);
  endtask
////////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    ref_clk_in = 1'h0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  // main sequence
  initial begin
    rst_in = 1'h1;
    powerdown_active_in = 1'h0;
    slot0_entry_in = 1'h0;
    powerdown_exit_in = 1'h0;
    restart_trials_in = 2'h0;
    ev_sys_set_in = 8'h00;
    ev_supply_set_in = 8'h00;
    ev_input_set_in = 8'h00;
    tick(16);
    rst_in = 1'h0;
    tick(2);
    t_regs();
    t_domain();
    t_policy();
    t_ctrl_c();
    t_irq();
    t_lock();
    results();
  end
  // watchdog, about twice the expected run
  initial begin
    #6000000;
    fails++;
    results();
  end
endmodule
bind pmr_ctrl_regs pmr_ctrl_regs_chk #(.WDOG_BASE_CYC(WDOG_BASE_CYC)) pmr_ctrl_regs_chk_i (
  .ref_clk_in, .rst_in, .powerdown_active_in, .slot0_entry_in, .powerdown_exit_in,
  .irq_request_out, .system_reset_output_n_out, .otp_default_supplies_load_out,
  .otp_reload_on_wake_out, .wakeup_block_out, .wdog_run_out, .wdog_enable_out,
  .wdog_timeout_cycles_out, .ramp_step_cycles_out, .ramp_step_cycles_wide_out);
`default_nettype wire
